// ==== common/tccfg_pkg.sv ====
// constants shared by the touch controller register block and its result sequencer
// assumes one 250 MHz clock and a serial front end that delivers whole bytes
package tccfg_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int NUM_STAGES = 12;
    // **********************************************
    // address map
    // **********************************************
    localparam logic [ADDR_W-1:0] ADDR_PWR_CONTROL = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_STAGE_CAL_EN = 10'h001;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_LAST = 10'h007;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN_A = 10'h005;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN_B = 10'h006;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN_C = 10'h007;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT_A = 10'h008;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT_B = 10'h009;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT_C = 10'h00a;
    localparam logic [ADDR_W-1:0] ADDR_CONV_DATA0 = 10'h00b;
    localparam logic [ADDR_W-1:0] ADDR_DEVICE_ID = 10'h017;
    localparam logic [ADDR_W-1:0] ADDR_BANK2_FIRST = 10'h080;
    localparam logic [ADDR_W-1:0] ADDR_BANK2_LAST = 10'h0df;
    localparam logic [ADDR_W-1:0] ADDR_BANK3_FIRST = 10'h0e0;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 10'h0eb;
    localparam int BANK2_WORDS = 96;
    // **********************************************
    // fields and reset values
    // **********************************************
    localparam int PWR_MODE_LSB = 0;
    localparam int STAGE_NUM_LSB = 4;
    localparam int SW_RESET_BIT = 10;
    localparam int INT_POL_BIT = 11;
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_LOW = 2'h2;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DEVICE_ID = 16'h5a10; // arbitrary value
    typedef enum logic [1:0] {PH_ADDR_HI, PH_ADDR_LO, PH_DATA_HI, PH_DATA_LO} tccfg_phase_e;
endpackage : tccfg_pkg

// ==== common/tccfg_res_if.sv ====
// carrier between the register block and the result sequencer
// assumes both ends share clk_i
`timescale 1ns/1ps
`default_nettype none
interface tccfg_res_if;
    import tccfg_pkg::*;
    logic cfg_done;
    logic [1:0] power_mode;
    logic [3:0] stage_last;
    logic stage_done;
    logic [3:0] stage;
    logic [DATA_W-1:0] raw;
    logic above_avg;
    logic seq_done;
    logic [DATA_W-1:0] avg [NUM_STAGES];
    modport seq (input cfg_done, power_mode, stage_last,
                 output stage_done, stage, raw, above_avg, seq_done, avg);
    modport regs (output cfg_done, power_mode, stage_last,
                  input stage_done, stage, raw, above_avg, seq_done, avg);
endinterface : tccfg_res_if
`default_nettype wire

// ==== src/tccfg_seq.sv ====
// conversion result sequencer: filters per-stage results and marks sequence ends
// assumes conversion words arrive as single-cycle strobes in stage order
`timescale 1ns/1ps
`default_nettype none
module tccfg_seq
    import tccfg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // converter side
    input wire logic conv_valid_i,
    input wire logic [3:0] conv_stage_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    // register block side
    tccfg_res_if.seq res
);
    logic [DATA_W-1:0] avg_r [NUM_STAGES];
    logic accept;
    logic [DATA_W-1:0] avg_nxt;

    // conversions are ignored until configured and while shut down
    assign accept = conv_valid_i && res.cfg_done && conv_stage_i <= res.stage_last
                    && (res.power_mode == MODE_FULL || res.power_mode == MODE_LOW);
    // half-step average: cheap, and slow enough to ride over a single noisy sample
    assign avg_nxt = DATA_W'(({1'b0, avg_r[conv_stage_i]} + {1'b0, conv_data_i}) >> 1);

    // **********************************************
    // per-stage filter memory
    // **********************************************
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < NUM_STAGES; i++)
                avg_r[i] <= REG_RESET;
        end
        else if (ce_i && accept)
        begin
            avg_r[conv_stage_i] <= avg_nxt;
        end
    end

    // event strobes towards the register block
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            res.stage_done <= 1'b0;
            res.seq_done <= 1'b0;
            res.stage <= 4'h0;
            res.raw <= REG_RESET;
            res.above_avg <= 1'b0;
        end
        else if (ce_i)
        begin
            res.stage_done <= accept;
            res.seq_done <= accept && conv_stage_i == res.stage_last;
            res.stage <= conv_stage_i;
            res.raw <= conv_data_i;
            res.above_avg <= conv_data_i > avg_r[conv_stage_i];
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_STAGES; i++)
            res.avg[i] = avg_r[i];
    end
endmodule : tccfg_seq
`default_nettype wire

// ==== src/tccfg_top.sv ====
// register banks and byte-level register port of the touch controller
// assumes a serial front end delivering start, stop and whole bytes in the clock domain
`timescale 1ns/1ps
`default_nettype none
module tccfg_top
    import tccfg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // byte port from the serial front end
    input wire logic xfer_start_i,
    input wire logic xfer_stop_i,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic rd_req_i,
    output logic [7:0] rd_byte_o,
    output logic rd_valid_o,
    // converter results
    input wire logic conv_valid_i,
    input wire logic [3:0] conv_stage_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    // status
    output logic int_o,
    output logic results_valid_o
);
    tccfg_res_if res ();

    tccfg_seq u_seq (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .conv_valid_i(conv_valid_i),
        .conv_stage_i(conv_stage_i),
        .conv_data_i(conv_data_i),
        .res(res)
    );

    // **********************************************
    // storage
    // **********************************************
    logic [DATA_W-1:0] ctrl_r [8];
    logic [DATA_W-1:0] stat_a_r, stat_b_r, stat_c_r;
    logic [DATA_W-1:0] conv_r [NUM_STAGES];
    logic [DATA_W-1:0] bank2_r [BANK2_WORDS];
    logic [DATA_W-1:0] bank3_r [NUM_STAGES];
    logic cfg_done_r;
    tccfg_phase_e phase_r;
    logic [1:0] addr_hi_r;
    logic [7:0] hold_r;
    logic [ADDR_W-1:0] ptr_r;
    logic past_end_r;
    logic rd_lo_r;

    logic word_wr, word_rd, sw_reset, advance;
    logic [DATA_W-1:0] wr_word, rd_word;
    logic [DATA_W-1:0] clr_a, clr_b, clr_c, set_a, set_b, set_c, stage_bit;

    // decoded word read, banks by range
    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = REG_RESET;
        if (a <= ADDR_CTRL_LAST)
            w = ctrl_r[a[2:0]];
        else if (a == ADDR_INT_STAT_A)
            w = stat_a_r;
        else if (a == ADDR_INT_STAT_B)
            w = stat_b_r;
        else if (a == ADDR_INT_STAT_C)
            w = stat_c_r;
        else if (a >= ADDR_CONV_DATA0 && a < ADDR_CONV_DATA0 + 10'(NUM_STAGES))
            w = conv_r[4'(a - ADDR_CONV_DATA0)];
        else if (a == ADDR_DEVICE_ID)
            w = DEVICE_ID;
        else if (a >= ADDR_BANK2_FIRST && a <= ADDR_BANK2_LAST)
            w = bank2_r[7'(a - ADDR_BANK2_FIRST)];
        else if (a >= ADDR_BANK3_FIRST && a <= ADDR_LAST)
            w = bank3_r[4'(a - ADDR_BANK3_FIRST)];
        return w;
    endfunction : read_word

    // **********************************************
    // byte framing
    // **********************************************
    assign wr_word = {hold_r, wr_byte_i};
    assign word_wr = wr_valid_i && phase_r == PH_DATA_LO && !past_end_r;
    assign word_rd = rd_req_i && rd_lo_r;
    assign advance = word_wr || word_rd || (wr_valid_i && phase_r == PH_DATA_LO);
    assign rd_word = read_word(ptr_r);
    assign sw_reset = word_wr && ptr_r == ADDR_PWR_CONTROL && wr_word[SW_RESET_BIT];

    // write phase: two address bytes, then data pairs; a lone high byte dies at stop
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            phase_r <= PH_ADDR_HI;
        else if (ce_i)
        begin
            if (xfer_start_i || xfer_stop_i)
                phase_r <= PH_ADDR_HI;
            else if (wr_valid_i)
            begin
                case (phase_r)
                    PH_ADDR_HI: phase_r <= PH_ADDR_LO;
                    PH_ADDR_LO: phase_r <= PH_DATA_HI;
                    PH_DATA_HI: phase_r <= PH_DATA_LO;
                    PH_DATA_LO: phase_r <= PH_DATA_HI;
                    default: phase_r <= PH_ADDR_HI;
                endcase
            end
        end
    end

    // address byte and data high byte holding
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            addr_hi_r <= 2'h0;
            hold_r <= 8'h00;
        end
        else if (ce_i && wr_valid_i)
        begin
            if (phase_r == PH_ADDR_HI)
                addr_hi_r <= wr_byte_i[1:0];
            if (phase_r == PH_DATA_HI)
                hold_r <= wr_byte_i;
        end
    end

    // pointer: no wrap, sticks at the last word so reads repeat it and writes drop
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            ptr_r <= 10'h000;
            past_end_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (xfer_stop_i)
            begin
                ptr_r <= 10'h000;
                past_end_r <= 1'b0;
            end
            else if (wr_valid_i && phase_r == PH_ADDR_LO)
            begin
                ptr_r <= {addr_hi_r, wr_byte_i};
                past_end_r <= {addr_hi_r, wr_byte_i} > ADDR_LAST;
            end
            else if (advance)
            begin
                if (ptr_r < ADDR_LAST)
                    ptr_r <= ptr_r + 10'h001;
                else
                    past_end_r <= 1'b1;
            end
        end
    end

    // read bytes: high then low, one answer per request
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rd_lo_r <= 1'b0;
            rd_byte_o <= 8'h00;
            rd_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_valid_o <= rd_req_i;
            if (xfer_start_i || xfer_stop_i)
                rd_lo_r <= 1'b0;
            else if (rd_req_i)
            begin
                rd_lo_r <= !rd_lo_r;
                rd_byte_o <= rd_lo_r ? rd_word[7:0] : rd_word[15:8];
            end
        end
    end

    // **********************************************
    // bank one control words
    // **********************************************
    // software reset restores defaults and leaves its own bit clear
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || (ce_i && sw_reset))
        begin
            for (int i = 0; i < 8; i++)
                ctrl_r[i] <= REG_RESET;
        end
        else if (ce_i && word_wr && ptr_r <= ADDR_CTRL_LAST)
        begin
            ctrl_r[ptr_r[2:0]] <= wr_word;
        end
    end

    // **********************************************
    // interrupt status: set on events, cleared by reading the low byte
    // **********************************************
    assign stage_bit = DATA_W'(1) << res.stage;
    assign set_a = res.stage_done ? (stage_bit & ctrl_r[ADDR_INT_EN_A[2:0]]) : REG_RESET;
    assign set_b = (res.stage_done && res.above_avg) ? (stage_bit & ctrl_r[ADDR_INT_EN_B[2:0]]) : REG_RESET;
    assign set_c = res.seq_done ? (stage_bit & ctrl_r[ADDR_INT_EN_C[2:0]]) : REG_RESET;
    assign clr_a = (word_rd && ptr_r == ADDR_INT_STAT_A) ? 16'hffff : 16'h0000;
    assign clr_b = (word_rd && ptr_r == ADDR_INT_STAT_B) ? 16'hffff : 16'h0000;
    assign clr_c = (word_rd && ptr_r == ADDR_INT_STAT_C) ? 16'hffff : 16'h0000;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || (ce_i && sw_reset))
        begin
            stat_a_r <= REG_RESET;
            stat_b_r <= REG_RESET;
            stat_c_r <= REG_RESET;
        end
        else if (ce_i)
        begin
            stat_a_r <= (stat_a_r & ~clr_a) | set_a;
            stat_b_r <= (stat_b_r & ~clr_b) | set_b;
            stat_c_r <= (stat_c_r & ~clr_c) | set_c;
        end
    end

    // pin level follows the programmed polarity; idle is the inactive level
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            int_o <= 1'b1;
        else if (ce_i)
            int_o <= ctrl_r[0][INT_POL_BIT] == (|{stat_a_r, stat_b_r, stat_c_r});
    end

    // **********************************************
    // banks two and three
    // **********************************************
    // configuration bank has no reset: contents mean nothing until loaded
    always_ff @(posedge clk_i)
    begin
        if (ce_i && word_wr && ptr_r >= ADDR_BANK2_FIRST && ptr_r <= ADDR_BANK2_LAST)
            bank2_r[7'(ptr_r - ADDR_BANK2_FIRST)] <= wr_word;
    end

    // writing the final configuration word marks the bank as loaded
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            cfg_done_r <= 1'b0;
        else if (ce_i && word_wr && ptr_r == ADDR_BANK2_LAST)
            cfg_done_r <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            results_valid_o <= 1'b0;
        else if (ce_i)
            results_valid_o <= cfg_done_r;
    end

    // raw words per stage, and the result bank copied whole at sequence end
    always_ff @(posedge clk_i)
    begin
        if (ce_i && res.stage_done)
            conv_r[res.stage] <= res.raw;
        if (ce_i && res.seq_done)
        begin
            for (int i = 0; i < NUM_STAGES; i++)
                bank3_r[i] <= res.avg[i];
        end
    end

    assign res.cfg_done = cfg_done_r;
    assign res.power_mode = ctrl_r[0][PWR_MODE_LSB +: 2];
    assign res.stage_last = ctrl_r[0][STAGE_NUM_LSB +: 4];
endmodule : tccfg_top
`default_nettype wire

// ==== bench/tccfg_monitor.sv ====
// checker on the ports of tccfg_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tccfg_monitor
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // watched ports
    input wire logic wr_valid_i,
    input wire logic rd_req_i,
    input wire logic conv_valid_i,
    input wire logic [7:0] rd_byte_o,
    input wire logic rd_valid_o,
    input wire logic int_o,
    input wire logic results_valid_o
);
    // **********************************************
    // properties
    // **********************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [3:0] act_r;
    // any cause of an interrupt change seen in the last four cycles
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            act_r <= 4'h0;
        else
            act_r <= {act_r[2:0], conv_valid_i | rd_req_i | wr_valid_i};
    end
    property p_rd_answer;
        rd_req_i && ce_i |=> rd_valid_o;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read byte not answered");
    property p_rd_cause;
        rd_valid_o && $past(ce_i) |-> $past(rd_req_i);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read byte without request");
    property p_rd_hold;
        !rd_req_i |=> $stable(rd_byte_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read byte moved without request");
    property p_res_keep;
        results_valid_o |=> results_valid_o;
    endproperty
    a_res_keep: assert property (p_res_keep) else $error("results valid dropped");
    property p_res_cause;
        $rose(results_valid_o) |-> $past(wr_valid_i, 2);
    endproperty
    a_res_cause: assert property (p_res_cause) else $error("results valid without write");
    property p_int_quiet;
        (!results_valid_o && !wr_valid_i && !rd_req_i) [*4] |-> $stable(int_o);
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("interrupt before configuration");
    property p_int_cause;
        $changed(int_o) |-> (|act_r);
    endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt moved without cause");
endmodule : tccfg_monitor
bind tccfg_top tccfg_monitor tccfg_monitor_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .wr_valid_i(wr_valid_i), .rd_req_i(rd_req_i), .conv_valid_i(conv_valid_i), .rd_byte_o(rd_byte_o),
    .rd_valid_o(rd_valid_o), .int_o(int_o), .results_valid_o(results_valid_o));
`default_nettype wire

// ==== bench/tccfg_host.sv ====
// host model driving the byte port of tccfg_top
// assumes strobes are taken at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tccfg_host
(
    // clock and read answer
    input wire logic clk_i,
    input wire logic [7:0] rd_byte_i,
    input wire logic rd_valid_i,
    // byte strobes
    output logic xfer_start_o,
    output logic xfer_stop_o,
    output logic wr_valid_o,
    output logic [7:0] wr_byte_o,
    output logic rd_req_o
);
    // **********************************************
    // byte transfers
    // **********************************************
    int miss = 0;
    initial {xfer_start_o, xfer_stop_o, wr_valid_o, wr_byte_o, rd_req_o} = '0;
    // all strobes redriven each cycle; an idle data byte flips so no stale value looks valid
    task automatic cyc(input logic st, input logic sp, input logic wv, input logic [7:0] b, input logic rr);
        @(negedge clk_i);
        xfer_start_o = st;
        xfer_stop_o = sp;
        wr_valid_o = wv;
        wr_byte_o = wv ? b : ~wr_byte_o;
        rd_req_o = rr;
    endtask : cyc
    task automatic addr(input logic [9:0] a);
        cyc(1, 0, 0, 8'h00, 0);
        cyc(0, 0, 1, {6'h00, a[9:8]}, 0);
        cyc(0, 0, 1, a[7:0], 0);
    endtask : addr
    task automatic wr(input logic [9:0] a, input logic [15:0] d[$]);
        addr(a);
        foreach (d[i])
        begin
            cyc(0, 0, 1, d[i][15:8], 0);
            cyc(0, 0, 1, d[i][7:0], 0);
        end
        cyc(0, 1, 0, 8'h00, 0);
    endtask : wr
    // one byte at a time: slower than back to back but never overlaps answers
    // the answer is taken in the cycle after the request, while rd_valid stands
    task automatic rbyte(output logic [7:0] b);
        cyc(0, 0, 0, 8'h00, 1);
        cyc(0, 0, 0, 8'h00, 0);
        if (rd_valid_i !== 1'b1)
            miss++;
        b = rd_byte_i;
    endtask : rbyte
    task automatic rd_here(input int n, output logic [15:0] q[$]);
        logic [7:0] h;
        logic [7:0] l;
        q = {};
        cyc(1, 0, 0, 8'h00, 0);
        repeat (n)
        begin
            rbyte(h);
            rbyte(l);
            q.push_back({h, l});
        end
        cyc(0, 1, 0, 8'h00, 0);
    endtask : rd_here
    task automatic rd(input logic [9:0] a, input int n, output logic [15:0] q[$]);
        addr(a);
        rd_here(n, q);
    endtask : rd
endmodule : tccfg_host
`default_nettype wire

// ==== bench/tb_tccfg_top.sv ====
// self-checking bench for tccfg_top: power-up load, readback, conversions, status
// assumes the host model drives the byte port
`timescale 1ns/1ps
`default_nettype none
module tb_tccfg_top
    import tccfg_pkg::*;
;
    // **********************************************
    // stimulus and checks
    // **********************************************
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic conv_valid_i = 1'b0;
    logic [3:0] conv_stage_i = 4'h0;
    logic [DATA_W-1:0] conv_data_i = 16'h0000;
    logic xs, xp, wv, rr, rd_valid_o, int_o, results_valid_o;
    logic [7:0] wb, rd_byte_o;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] q[$];
    logic [15:0] b[$];
    always #2 clk_i = ~clk_i;
    tccfg_host tccfg_host_i (.clk_i(clk_i), .rd_byte_i(rd_byte_o), .rd_valid_i(rd_valid_o), .xfer_start_o(xs),
        .xfer_stop_o(xp), .wr_valid_o(wv), .wr_byte_o(wb), .rd_req_o(rr));
    tccfg_top tccfg_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .xfer_start_i(xs),
        .xfer_stop_i(xp), .wr_valid_i(wv), .wr_byte_i(wb), .rd_req_i(rr), .rd_byte_o(rd_byte_o),
        .rd_valid_o(rd_valid_o), .conv_valid_i(conv_valid_i), .conv_stage_i(conv_stage_i),
        .conv_data_i(conv_data_i), .int_o(int_o), .results_valid_o(results_valid_o));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // hang guard, well above the under one thousand cycles the sequence needs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end
    task automatic conv(input logic [3:0] s);
        @(negedge clk_i);
        conv_valid_i = 1'b1;
        conv_stage_i = s;
        conv_data_i = 16'h0200 + 16'(s);
    endtask : conv
    task automatic settle;
        @(negedge clk_i);
        conv_valid_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : settle
    initial
    begin
        repeat (5) @(negedge clk_i);
        reset_n_i = 1'b1;
        @(negedge clk_i);
        chk("reset flags", 16'h0002, {13'h0, rd_valid_o, int_o, results_valid_o});
        for (int i = 0; i < 95; i++)
            b.push_back(16'h1000 + 16'(i));
        tccfg_host_i.wr(10'h080, b);
        chk("valid early", 16'h0000, {15'h0, results_valid_o});
        b = {16'h105f};
        tccfg_host_i.wr(10'h0df, b);
        // the loaded flag reaches the pin one registered stage later
        @(negedge clk_i);
        chk("valid loaded", 16'h0001, {15'h0, results_valid_o});
        tccfg_host_i.rd(10'h080, 96, q);
        foreach (q[i])
            chk("config bank", 16'h1000 + 16'(i), q[i]);
        b = {16'h82b2, 16'h0000, 16'h3230, 16'h0419, 16'h0340, 16'h0fff, 16'h0000, 16'h0800};
        tccfg_host_i.wr(10'h000, b);
        tccfg_host_i.rd(10'h000, 8, q);
        foreach (q[i])
            chk("control bank", b[i], q[i]);
        b = {16'h0fff};
        tccfg_host_i.wr(10'h001, b);
        tccfg_host_i.rd_here(1, q);
        chk("pointer after stop", 16'h82b2, q[0]);
        tccfg_host_i.rd(10'h001, 1, q);
        chk("cal enable", 16'h0fff, q[0]);
        tccfg_host_i.rd(10'h017, 1, q);
        chk("device id", DEVICE_ID, q[0]);
        tccfg_host_i.rd(10'h050, 1, q);
        chk("unmapped", 16'h0000, q[0]);
        chk("int idle", 16'h0001, {15'h0, int_o});
        for (int s = 0; s < 12; s++)
            conv(4'(s));
        settle();
        chk("int raised", 16'h0000, {15'h0, int_o});
        tccfg_host_i.rd(10'h008, 3, q);
        chk("status a", 16'h0fff, q[0]);
        chk("status b", 16'h0000, q[1]);
        chk("status c", 16'h0800, q[2]);
        @(negedge clk_i);
        chk("int cleared", 16'h0001, {15'h0, int_o});
        tccfg_host_i.rd(10'h00b, 12, q);
        foreach (q[i])
            chk("raw word", 16'h0200 + 16'(i), q[i]);
        conv(4'h0);
        settle();
        chk("int again", 16'h0000, {15'h0, int_o});
        tccfg_host_i.rd(10'h008, 1, q);
        chk("status again", 16'h0001, q[0]);
        b = {16'hffff};
        tccfg_host_i.wr(10'h008, b);
        tccfg_host_i.rd(10'h008, 1, q);
        chk("status read only", 16'h0000, q[0]);
        tccfg_host_i.rd(10'h0ea, 3, q);
        chk("result bank", 16'h0105, q[1]);
        chk("last address repeats", 16'h0105, q[2]);
        // a frozen clock enable must swallow a conversion strobe
        ce_i = 1'b0;
        conv(4'h0);
        settle();
        ce_i = 1'b1;
        chk("int frozen", 16'h0001, {15'h0, int_o});
        tccfg_host_i.rd(10'h008, 1, q);
        chk("status frozen", 16'h0000, q[0]);
        // shutdown mode ignores conversions
        b = {16'h82b1};
        tccfg_host_i.wr(10'h000, b);
        conv(4'h0);
        settle();
        tccfg_host_i.rd(10'h008, 1, q);
        chk("shutdown ignores", 16'h0000, q[0]);
        chk("read answers", 16'h0000, 16'(tccfg_host_i.miss));
        complete_run();
    end
endmodule : tb_tccfg_top
`default_nettype wire
